// ### shared/ddbp_pkg.sv
// Package of constants and types for the drive data byte packing block
package ddbp_pkg;
   localparam int          DDBP_BUS_W      = 16;
   localparam int          DDBP_BYTE_W     = 8;
   localparam int          DDBP_CNT_W      = 16;
   localparam logic [7:0]  DDBP_ASCII_LO   = 8'h20;
   localparam logic [7:0]  DDBP_ASCII_HI   = 8'h7E;
   localparam logic [7:0]  DDBP_ASCII_FILL = 8'h20;
   localparam logic [15:0] DDBP_MIN_BURST  = 16'h0002;
   localparam logic [15:0] DDBP_DATA_RST   = 16'h0000;
   localparam logic [15:0] DDBP_CNT_RST    = 16'h0000;

   typedef enum logic [1:0]
   {
      DDBP_ST_IDLE = 2'b00,
      DDBP_ST_PIO  = 2'b01,
      DDBP_ST_DMA  = 2'b10
   } ddbp_state_t;

   // Host-side strobes from the pins, synchronised to clock inside the block
   typedef struct packed
   {
      logic pio_strobe;
      logic dmack;
   } ddbp_host_t;

   // Status presented to the host
   typedef struct packed
   {
      logic busy_flag;
      logic data_request_flag;
      logic dmarq;
   } ddbp_stat_t;
endpackage : ddbp_pkg

// ### src/ddbp_ascii.sv
// Byte-lane swapper and printable filter for ASCII parameter words
`timescale 1ns/100ps
module ddbp_ascii
(
   input  wire logic [15:0] first_pair,   // First character in [7:0], second in [15:8]
   output wire logic [15:0] bus_word      // Word as placed on the data lines
);
   import ddbp_pkg::*;

   function automatic logic [7:0] ddbp_printable(input logic [7:0] ch);
      logic ok;
      ok = (ch >= DDBP_ASCII_LO) && (ch <= DDBP_ASCII_HI);
      // Non-printable codes are replaced; only 8-bit PIO passes them to the host unfiltered
      return ok ? ch : DDBP_ASCII_FILL;
   endfunction : ddbp_printable

   // Odd-numbered character goes to the high lane
   assign bus_word = {ddbp_printable(first_pair[7:0]),
                      ddbp_printable(first_pair[15:8])};
endmodule : ddbp_ascii

// ### src/ddbp_top.sv
// Device-side data-phase byte packing and transfer qualification
// Functional notes
// - A PIO word moves only while busy is clear and data request is set.
// - PIO uses 16-bit words, with an optional 8-bit width selected by a strap input.
// - A PIO data-request block holds one or more bytes moved as a group.
// - A DMA transfer starts only after the device requests and the host acknowledges.
// - Every DMA transfer uses the full 16-bit bus.
// - One acknowledge assertion delimits a burst, which carries at least two bytes.
// - In 16-bit mode word k carries byte 2k low and byte 2k+1 high.
// - In 8-bit PIO each byte goes alone on the low lines in ascending order.
// - ASCII fields carry only codes 20h through 7Eh; 8-bit PIO passes text bytes unfiltered.
// - The first of each ASCII character pair sits on the high lane; 8-bit PIO sends it first on the low lines.
// - The state machine moves between states with no idle cycles in between.
// - Entering a state, even from itself, repeats all of that state's actions.
// - The device is configured as unit 0 or unit 1.
// - The unit number comes from a jumper or the sampled cable-select pin.
`timescale 1ns/100ps
module ddbp_top
#(
   parameter int BLK_BYTES = 512                      // Bytes in one data-request block
)
(
   input  wire logic                 clock,           // 10 MHz clock
   input  wire logic                 rst_b,           // Async reset, active low
   input  wire ddbp_pkg::ddbp_host_t host_in,         // Host strobes from pins
   input  wire logic                 csel_pin,        // Cable-select pin level
   input  wire logic                 jumper_unit,     // Jumper unit number
   input  wire logic                 use_csel,        // High: unit from cable select
   input  wire logic                 width8_strap,    // High: 8-bit PIO
   input  wire logic                 start_pio,       // Pulse: begin a PIO block
   input  wire logic                 start_dma,       // Pulse: begin a DMA burst
   input  wire logic                 ascii_mode,      // High: block is ASCII text
   input  wire logic [15:0]          src_data,        // Next two source bytes, lower first
   output logic                      src_take,        // Pulse: src_data consumed
   output logic [15:0]               dd_out,          // Data lines driven to host
   output logic                      dd_oe,           // High while driving data
   output ddbp_pkg::ddbp_stat_t      stat_out,        // Busy, request, DMA request
   output logic                      unit_sel,        // Configured unit, 0 or 1
   output logic                      block_done       // Pulse: block or burst ended
);
   import ddbp_pkg::*;

   localparam logic [15:0] BLK_LAST = 16'(BLK_BYTES - 1);

   ddbp_state_t state_reg;
   ddbp_state_t state_next;
   logic [1:0]  pio_sync1_reg;
   logic [1:0]  pio_sync2_reg;
   logic        pio_prev_reg;
   logic [1:0]  csel_sync_reg;
   logic [1:0]  jmp_sync_reg;
   logic [1:0]  use_sync_reg;
   logic        strap_done_reg;
   logic        w8_reg;
   logic        lane_hi_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        dmack_prev_reg;
   logic        unit_reg;

   // Host strobes cross from pins through two flops each
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pio_sync1_reg <= 2'h0;
         pio_sync2_reg <= 2'h0;
      end
      else
      begin
         pio_sync1_reg <= {host_in.dmack, host_in.pio_strobe};
         pio_sync2_reg <= pio_sync1_reg;
      end
   end

   // Strap syncs skip reset so they hold settled pin levels at the latch
   always_ff @(posedge clock)
   begin
      csel_sync_reg <= {csel_sync_reg[0], csel_pin};
      jmp_sync_reg  <= {jmp_sync_reg[0], jumper_unit};
      use_sync_reg  <= {use_sync_reg[0], use_csel};
   end

   wire pio_s   = pio_sync2_reg[0];
   wire dmack_s = pio_sync2_reg[1];
   wire pio_rise = pio_s && !pio_prev_reg;
   wire dmack_rise = dmack_s && !dmack_prev_reg;
   wire dmack_fall = !dmack_s && dmack_prev_reg;

   // Straps latch once after release; later changes need a reset
   wire strap_unit = use_sync_reg[1] ? csel_sync_reg[1] : jmp_sync_reg[1];

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         strap_done_reg <= 1'b0;
      else
         strap_done_reg <= 1'b1;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         unit_reg <= 1'b0;
      else if (!strap_done_reg)
         unit_reg <= strap_unit;
   end

   // Width is read once; a change in mid-block would tear the byte count
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         w8_reg <= 1'b0;
      else if (!strap_done_reg)
         w8_reg <= width8_strap;
   end

   // Qualification of each host strobe against the current state
   wire in_pio   = (state_reg == DDBP_ST_PIO);
   wire in_dma   = (state_reg == DDBP_ST_DMA);
   wire pio_xfer = in_pio && pio_rise;
   wire dma_xfer = in_dma && dmack_s && pio_rise;
   wire xfer     = pio_xfer || dma_xfer;
   wire narrow   = in_pio && w8_reg;
   wire [15:0] step = narrow ? 16'h0001 : 16'h0002;
   wire [15:0] cnt_inc = cnt_reg + step;
   wire pio_end  = pio_xfer && (cnt_inc > BLK_LAST);
   // Burst ends only with the acknowledge, after at least one word
   wire dma_end  = in_dma && dmack_fall && (cnt_reg >= DDBP_MIN_BURST);
   wire lane_step = pio_xfer && narrow && !lane_hi_reg;

   // Next state is taken combinationally so each move lands on the next edge
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         DDBP_ST_IDLE:
         begin
            cnt_next = DDBP_CNT_RST;
            if (start_pio)
               state_next = DDBP_ST_PIO;
            else if (start_dma)
               state_next = DDBP_ST_DMA;
         end
         DDBP_ST_PIO:
         begin
            if (pio_end)
            begin
               state_next = start_pio ? DDBP_ST_PIO : DDBP_ST_IDLE;
               cnt_next   = DDBP_CNT_RST;
            end
            else if (pio_xfer)
               cnt_next = cnt_inc;
         end
         DDBP_ST_DMA:
         begin
            if (dma_end)
            begin
               state_next = start_dma ? DDBP_ST_DMA : DDBP_ST_IDLE;
               cnt_next   = DDBP_CNT_RST;
            end
            else if (dma_xfer)
               cnt_next = cnt_inc;
         end
         default:
         begin
            state_next = DDBP_ST_IDLE;
            cnt_next   = DDBP_CNT_RST;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= DDBP_ST_IDLE;
         cnt_reg   <= DDBP_CNT_RST;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Previous synced levels rest low like the pins, so reset makes no edge
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pio_prev_reg   <= 1'b0;
         dmack_prev_reg <= 1'b0;
      end
      else
      begin
         pio_prev_reg   <= pio_s;
         dmack_prev_reg <= dmack_s;
      end
   end

   // Byte packing of the source pair onto the bus
   wire [15:0] ascii_word;

   ddbp_ascii u_ascii
   (
      .first_pair (src_data),
      .bus_word   (ascii_word)
   );

   // Lane layout follows the next state, so the word that goes out with the
   // first enable of a narrow block already has its high lane cleared
   wire narrow_out = (state_next == DDBP_ST_PIO) && w8_reg;

   function automatic logic [15:0] ddbp_pack
   (
      input logic [15:0] pair,     // Byte 2k low, 2k+1 high
      input logic [15:0] text,     // Same pair in text layout
      input logic        w8,       // Narrow transfer
      input logic        hi,       // Second byte of the pair is due
      input logic        asc       // Pair is text
   );
      logic [7:0] lane;
      lane = hi ? pair[15:8] : pair[7:0];
      if (w8)
         return {8'h00, lane};
      return asc ? text : pair;
   endfunction : ddbp_pack

   wire [15:0] word_sel = ddbp_pack(src_data, ascii_word, narrow_out, lane_hi_reg, ascii_mode);
   // Source pair is consumed only when both its bytes have gone out
   wire take_now = xfer && !lane_step;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         lane_hi_reg <= 1'b0;
      else if (state_next != state_reg || pio_end || dma_end)
         lane_hi_reg <= 1'b0;
      else if (pio_xfer && narrow)
         lane_hi_reg <= !lane_hi_reg;
   end

   // Status is a plain decode of the state about to be held
   function automatic ddbp_stat_t ddbp_status(input ddbp_state_t st);
      ddbp_stat_t s;
      s.busy_flag         = (st != DDBP_ST_PIO);
      s.data_request_flag = (st == DDBP_ST_PIO);
      s.dmarq             = (st == DDBP_ST_DMA);
      return s;
   endfunction : ddbp_status

   wire ddbp_stat_t stat_next = ddbp_status(state_next);
   wire             oe_next   = stat_next.data_request_flag || (stat_next.dmarq && dmack_s);

   // Outputs, all registered
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dd_out <= DDBP_DATA_RST;
         dd_oe  <= 1'b0;
      end
      else
      begin
         dd_out <= word_sel;
         dd_oe  <= oe_next;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         stat_out <= '{busy_flag: 1'b1, data_request_flag: 1'b0, dmarq: 1'b0};
      else
         stat_out <= stat_next;
   end

   // Pulses last one cycle; the source side must act on the same edge
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         src_take   <= 1'b0;
         block_done <= 1'b0;
      end
      else
      begin
         src_take   <= take_now;
         block_done <= pio_end || dma_end;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         unit_sel <= 1'b0;
      else
         unit_sel <= unit_reg;
   end
endmodule : ddbp_top

// ### tb/ddbp_checker.sv
// Port checker for the drive data byte packing block
`timescale 1ns/100ps
module ddbp_checker
(
   input wire logic                 clock,        // Clock
   input wire logic                 rst_b,        // Reset
   input wire ddbp_pkg::ddbp_host_t host_in,      // Strobes
   input wire logic                 start_pio,    // PIO start
   input wire logic                 start_dma,    // DMA start
   input wire logic                 width8_strap, // Width
   input wire logic                 ascii_mode,   // Text
   input wire logic [15:0]          src_data,     // Source
   input wire logic [15:0]          dd_out,       // Data
   input wire logic                 dd_oe,        // Enable
   input wire ddbp_pkg::ddbp_stat_t stat_out,     // Status
   input wire logic                 block_done    // End
);
   import ddbp_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   function automatic logic [7:0] prn(input logic [7:0] c);
      return (c >= DDBP_ASCII_LO && c <= DDBP_ASCII_HI) ? c : DDBP_ASCII_FILL;
   endfunction : prn
   sequence idle_s;
      stat_out.busy_flag && !stat_out.data_request_flag && !stat_out.dmarq;
   endsequence
   // Four low samples cover the two-flop sync plus the output register
   sequence no_ack_s;
      !host_in.dmack [*4];
   endsequence
   a_pio_enter:
      assert property (start_pio ##0 idle_s |=>
         !stat_out.busy_flag && stat_out.data_request_flag && dd_oe) else $error("pio entry");
   a_dma_request:
      assert property (start_dma ##0 idle_s |=> stat_out.dmarq && !dd_oe) else $error("dma req");
   a_no_ack_quiet:
      assert property (no_ack_s ##0 stat_out.dmarq |-> !dd_oe) else $error("drive no ack");
   a_idle_quiet:
      assert property (idle_s |-> !dd_oe) else $error("drive in idle");
   a_word_order:
      assert property (!width8_strap && !$past(ascii_mode) && dd_oe |-> dd_out == $past(src_data))
         else $error("word order");
   a_narrow_lane:
      assert property (width8_strap && dd_oe |-> dd_out[15:8] == 8'h00) else $error("8 bit lane");
   a_text_high:
      assert property ($past(ascii_mode) && dd_oe && !width8_strap |->
         dd_out[15:8] == prn($past(src_data[7:0]))) else $error("text high lane");
   a_text_low:
      assert property ($past(ascii_mode) && dd_oe && !width8_strap |->
         dd_out[7:0] == prn($past(src_data[15:8]))) else $error("text low lane");
   a_done_release:
      assert property (block_done |-> ##[0:2] idle_s) else $error("no idle after end");
endmodule : ddbp_checker

// ### tb/ddbp_host_model.sv
// Host model that strobes words out of the device
`timescale 1ns/100ps
module ddbp_host_model
(
   input  wire logic                 clock,    // Clock
   input  wire ddbp_pkg::ddbp_stat_t stat_out, // Device status
   input  wire logic [15:0]          dd_out,   // Device data
   input  wire logic                 dd_oe,    // Device enable
   input  wire logic [7:0]           n_words,  // Strobes to issue
   input  wire logic                 go,       // Load n_words
   output ddbp_pkg::ddbp_host_t      host_in   // Strobes to device
);
   import ddbp_pkg::*;
   logic [15:0] got [$];
   int left = 0, gap = 0, req_age = 0;
   initial host_in = '0;
   // Ten-cycle pacing lets the synced strobe and the next source pair settle
   always @(posedge clock)
   begin
      if (go === 1'b1)
         left = n_words;
      #1;
      req_age = stat_out.dmarq ? req_age + 1 : 0;
      if (req_age == 6 && left > 0)
         host_in.dmack = 1'b1;
      gap = (gap == 9) ? 0 : gap + 1;
      if (gap == 2)
         host_in.pio_strobe = 1'b0;
      if (gap == 0 && left > 0 && dd_oe &&
          (!stat_out.busy_flag && stat_out.data_request_flag || host_in.dmack))
      begin
         got.push_back(dd_out);
         host_in.pio_strobe = 1'b1;
         left--;
      end
      if (gap == 9 && left == 0)
         host_in.dmack = 1'b0;
   end
endmodule : ddbp_host_model

// ### tb/tb.sv
// Bench for the drive data byte packing block
`timescale 1ns/100ps
module tb;
   import ddbp_pkg::*;
   localparam int BLK = 8;
   logic clock = 0, rst_b = 0, csel_pin = 0, jumper_unit = 0, use_csel = 0, width8_strap = 0;
   logic start_pio = 0, start_dma = 0, ascii_mode = 0, go = 0, src_take, dd_oe, unit_sel;
   logic block_done;
   logic [15:0] src_data = '0, dd_out;
   logic [7:0]  n_words = '0;
   ddbp_host_t  host_in;
   ddbp_stat_t  stat_out;
   logic [15:0] pairs [$];
   int idx = 0, dones = 0, n_fail = 0, compares = 0;
   ddbp_top #(.BLK_BYTES(BLK)) ddbp_top_inst
   (
      .clock(clock), .rst_b(rst_b), .host_in(host_in), .csel_pin(csel_pin),
      .jumper_unit(jumper_unit), .use_csel(use_csel), .width8_strap(width8_strap),
      .start_pio(start_pio), .start_dma(start_dma), .ascii_mode(ascii_mode),
      .src_data(src_data), .src_take(src_take), .dd_out(dd_out), .dd_oe(dd_oe),
      .stat_out(stat_out), .unit_sel(unit_sel), .block_done(block_done)
   );
   ddbp_host_model ddbp_host_model_inst
   (
      .clock(clock), .stat_out(stat_out), .dd_out(dd_out), .dd_oe(dd_oe),
      .n_words(n_words), .go(go), .host_in(host_in)
   );
   initial
   begin
      forever #50 clock = ~clock;
   end
   function automatic logic [7:0] prn(input logic [7:0] c);
      return (c >= 8'h20 && c <= 8'h7E) ? c : 8'h20;
   endfunction : prn
   function automatic logic [15:0] exp_word(input int k, input logic asc, input logic w8);
      logic [15:0] p;
      p = pairs[w8 ? k / 2 : k];
      if (w8)
         return {8'h00, k[0] ? p[15:8] : p[7:0]};
      return asc ? {prn(p[7:0]), prn(p[15:8])} : p;
   endfunction : exp_word
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic do_reset(input logic w8);
      rst_b = 1'b0;
      width8_strap = w8;
      {csel_pin, jumper_unit, use_csel} = 3'($urandom);
      repeat (6) @(posedge clock);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(16'(stat_out), 16'h0004);
      chk(16'(unit_sel), 16'(use_csel ? csel_pin : jumper_unit));
   endtask : do_reset
   task automatic run(input logic dma, input logic asc, input int nw);
      int k;
      pairs.delete();
      for (k = 0; k <= nw; k++)
         pairs.push_back(16'($urandom));
      if (asc)
      begin
         pairs[0] = 16'h7E1F;
         pairs[1] = 16'h7F20;
      end
      ddbp_host_model_inst.got.delete();
      {idx, dones, src_data, ascii_mode, n_words, go} = {32'd0, 32'd0, pairs[0], asc, 8'(nw), 1'b1};
      {start_pio, start_dma} = {!dma, dma};
      @(posedge clock);
      #1 {go, start_pio, start_dma} = 3'b000;
      for (k = 0; k < 400 && dones == 0; k++)
         @(posedge clock);
      if (dones == 0)
      begin
         n_fail++;
         complete_run();
      end
      repeat (3) @(posedge clock);
      #1 chk(16'(ddbp_host_model_inst.got.size()), 16'(nw));
      for (k = 0; k < nw; k++)
         chk(ddbp_host_model_inst.got[k], exp_word(k, asc, width8_strap));
      chk(16'(stat_out), 16'h0004);
   endtask : run
   // Source pairs advance only on the take pulse, as a real buffer would
   always @(posedge clock)
   begin
      #1;
      if (block_done === 1'b1)
         dones++;
      if (src_take === 1'b1 && idx < pairs.size() - 1)
         src_data = pairs[++idx];
   end
   initial
   begin
      void'($urandom(26389));
      do_reset(1'b0);
      run(1'b0, 1'b0, BLK / 2);
      run(1'b0, 1'b1, BLK / 2);
      run(1'b1, 1'b0, 2 + $urandom_range(3));
      do_reset(1'b1);
      run(1'b0, 1'b0, BLK);
      complete_run();
   end
endmodule : tb
bind ddbp_top ddbp_checker ddbp_checker_inst
(
   .clock(clock), .rst_b(rst_b), .host_in(host_in), .start_pio(start_pio),
   .start_dma(start_dma), .width8_strap(width8_strap), .ascii_mode(ascii_mode),
   .src_data(src_data), .dd_out(dd_out), .dd_oe(dd_oe), .stat_out(stat_out),
   .block_done(block_done)
);
